// file: tdfs_regs.svh
// register offsets, field positions, reset values and limits of the
// turbo decoder format and stop block; included by its bare name
`ifndef TDFS_REGS_SVH
`define TDFS_REGS_SVH
`define TDFS_OFF_CTRL 8'h00
`define TDFS_OFF_ITER 8'h04
`define TDFS_OFF_CRC 8'h08
`define TDFS_OFF_POLY 8'h0C
`define TDFS_OFF_STAT 8'h10
`define TDFS_CTRL_GO 0
`define TDFS_CTRL_LITTLE 1
`define TDFS_CTRL_INTR 2
`define TDFS_CTRL_MSBF 3
`define TDFS_CTRL_RST 32'h0000_0002
`define TDFS_ITER_RST 32'h0000_0000
`define TDFS_CRC_RST 32'h0000_0000
`define TDFS_POLY_RST 32'h0000_0000
`define TDFS_MAX_ITER_ZERO 6'h20
`define TDFS_MIN_ITER_ZERO 6'h01
`define TDFS_IDX_BITS 15
`define TDFS_HW_BITS 16
`define TDFS_WORD_BITS 32
`define TDFS_SAMP_BITS 6
`define TDFS_RESP_OKAY 2'h0
`define TDFS_RESP_SLVERR 2'h2
`endif

// file: tdfs_pkg.sv
// types shared by the format and stop block
// assumes tdfs_regs.svh is on the include path
package tdfs_pkg;
   typedef enum logic [2:0] {
      ST_IDLE, ST_MAP1, ST_MAP2, ST_HARD, ST_FINAL, ST_DONE
   } tdfs_state_e;

   typedef struct packed {
      logic [31:0] poly;
      logic [5:0] crcPolyLength;
      logic [4:0] crcConsecutivePassCount;
      logic [6:0] snrThr;
      logic [4:0] maxIter;
      logic [4:0] minIter;
      logic msbFirst;
      logic intrSel;
      logic little;
   } tdfs_cfg_s;

   typedef struct packed {
      logic [63:0] data;
      logic valid;
   } tdfs_dword_s;
endpackage

// file: tdfs_endian.sv
// halfword rearrangement of one interleaver double word
// assumes halfword 0 sits in bits 15:0 of the incoming double word
`timescale 1ns/100ps
`include "tdfs_regs.svh"
module tdfs_endian
   import tdfs_pkg::*;
(
   // mode
   input wire logic little,
   input wire logic intrSel,
   // data
   input wire logic [63:0] dwIn,
   output logic [63:0] dwOut
);
   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : gHw
         logic [1:0] src;
         always_comb begin
            if (little) begin
               src = 2'(g);
            end else if (intrSel) begin
               src = 2'(3 - g);
            end else begin
               src = 2'(g ^ 2);
            end
         end
         // top bit of each entry is unused and forced to zero
         assign dwOut[g*16 +: 16] = {1'b0, dwIn[src*16 +: `TDFS_IDX_BITS]};
      end
   endgenerate
endmodule

// file: tdfs_pack.sv
// packs hard-decision bits into 32-bit words for the DMA side
// assumes one bit per cycle at most and a last marker on the final bit
`timescale 1ns/100ps
`include "tdfs_regs.svh"
module tdfs_pack
   import tdfs_pkg::*;
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic arst_n,
   // decision stream
   input wire logic enable,
   input wire logic msbFirst,
   input wire logic bitIn,
   input wire logic bitValid,
   input wire logic bitLast,
   // packed words
   output logic [31:0] word,
   output logic wordValid
);
   logic [31:0] acc_r, acc_nxt;
   logic [4:0] cnt_r, cnt_nxt;
   logic odd_r, odd_nxt;
   logic pad_r, pad_nxt;
   logic [31:0] word_r, word_nxt;
   logic wv_r, wv_nxt;
   logic [31:0] accIn;

   always_comb begin
      accIn = acc_r;
      accIn[msbFirst ? 5'(31 - cnt_r) : cnt_r] = bitIn;
      acc_nxt = acc_r;
      cnt_nxt = cnt_r;
      odd_nxt = odd_r;
      pad_nxt = 1'b0;
      word_nxt = word_r;
      wv_nxt = 1'b0;
      if (pad_r) begin
         // odd word count is evened out with a zero word
         word_nxt = '0;
         wv_nxt = 1'b1;
         odd_nxt = 1'b0;
      end else if (enable && bitValid) begin
         if (cnt_r == 5'h1F || bitLast) begin
            word_nxt = accIn;
            wv_nxt = 1'b1;
            acc_nxt = '0;
            cnt_nxt = '0;
            odd_nxt = bitLast ? 1'b0 : !odd_r;
            pad_nxt = bitLast && !odd_r;
         end else begin
            acc_nxt = accIn;
            cnt_nxt = cnt_r + 5'h01;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         acc_r <= '0;
         cnt_r <= '0;
         odd_r <= 1'b0;
         pad_r <= 1'b0;
         word_r <= '0;
         wv_r <= 1'b0;
      end else begin
         acc_r <= acc_nxt;
         cnt_r <= cnt_nxt;
         odd_r <= odd_nxt;
         pad_r <= pad_nxt;
         word_r <= word_nxt;
         wv_r <= wv_nxt;
      end
   end

   assign word = word_r;
   assign wordValid = wv_r;
endmodule

// file: tdfs_top.sv
// turbo decoder standalone data formatting and iteration stop control
// assumes MAP engine, decision source and sample store run on ref_clk
// How it works
// - index is 15 bits right-justified in halfword
// - interleaved sample j is read at entry j
// - big endian reorders halfwords; little leaves them
// - decisions packed one bit per 32-bit position
// - oldest decision at MSB or LSB, programmable
// - fixed iteration count or bounded stopping tests
// - SNR threshold 1..100 enables, 0 disables
// - ready event at max or when all enabled stop conditions hold
// - executed iteration count readable afterwards
// - nonzero CRC length enables CRC; pass count zero means one
// - each checked iteration computes decisions and CRC
// - CRC polynomial is programmable 32-bit value
// - CRC needs consecutive passes; failure restarts count
// - max zero means 32; stop at max
// - min zero means one; no earlier stop
// - SNR must exceed threshold on two consecutive MAPs
// - two MAPs per iteration, last runs first only
`timescale 1ns/100ps
`include "tdfs_regs.svh"
module tdfs_top
   import tdfs_pkg::*;
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic arst_n,
   // AXI4-Lite register slave
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // MAP engine
   output logic mapStart,
   output logic mapInterleaved,
   output logic [6:0] snrThreshold,
   input wire logic mapDone,
   input wire logic snrAbove,
   // hard decisions
   output logic hardStart,
   input wire logic decBit,
   input wire logic decValid,
   input wire logic decLast,
   // interleaver table and sample store
   input wire logic [63:0] tblData,
   input wire logic tblValid,
   output logic tblReady,
   output logic sampRdEn,
   output logic [14:0] sampRdAddr,
   input wire logic [5:0] sampRdData,
   output logic [5:0] ilvSample,
   output logic ilvValid,
   // DMA side
   output logic [31:0] decWord,
   output logic decWordValid,
   output logic decoderReceiveReadyEvent
);
   tdfs_cfg_s cfg_r, cfg_nxt;
   logic go;

   // register slave
   logic [7:0] awAddr_r, awAddr_nxt;
   logic awHeld_r, awHeld_nxt;
   logic [31:0] wData_r, wData_nxt;
   logic [3:0] wStrb_r, wStrb_nxt;
   logic wHeld_r, wHeld_nxt;
   logic bValid_r, bValid_nxt;
   logic [1:0] bResp_r, bResp_nxt;
   logic rValid_r, rValid_nxt;
   logic [31:0] rData_r, rData_nxt;
   logic [1:0] rResp_r, rResp_nxt;
   logic doWrite;
   logic [31:0] ctrlRd, iterRd, crcRd, statRd, merged;

   // stop control
   tdfs_state_e st_r, st_nxt;
   logic [5:0] iter_r, iter_nxt;
   logic [5:0] iterRun_r, iterRun_nxt;
   logic snrPrev_r, snrPrev_nxt;
   logic snrMet_r, snrMet_nxt;
   logic [4:0] crcCnt_r, crcCnt_nxt;
   logic [31:0] crc_r, crc_nxt;
   logic decPass_r, decPass_nxt;
   logic done_r, done_nxt;
   logic evt_r, evt_nxt;
   logic mapStart_r, mapStart_nxt;
   logic hardStart_r, hardStart_nxt;
   logic [5:0] maxEff, minEff, iterInc, lenM1;
   logic [4:0] passReq;
   logic snrEn, crcEn, crcMet, earlyOk, fb;
   logic [31:0] lenMask, crcStep;

   // interleaver path
   logic [63:0] dwSwap;
   logic [63:0] dw_r, dw_nxt;
   logic dwHeld_r, dwHeld_nxt;
   logic [1:0] hw_r, hw_nxt;
   logic rdEn_r, rdEn_nxt;
   logic [14:0] rdAddr_r, rdAddr_nxt;
   logic [5:0] ilv_r, ilv_nxt;
   logic ilvV_r, ilvV_nxt;

   assign ctrlRd = {28'h000_0000, cfg_r.msbFirst, cfg_r.intrSel, cfg_r.little, 1'b0};
   assign iterRd = {9'h000, cfg_r.snrThr, 3'h0, cfg_r.maxIter, 3'h0, cfg_r.minIter};
   assign crcRd = {19'h0_0000, cfg_r.crcConsecutivePassCount, 2'h0, cfg_r.crcPolyLength};
   assign statRd = {21'h00_0000, done_r, st_r != ST_IDLE, decPass_r, 2'h0, iterRun_r};

   always_comb begin
      awAddr_nxt = awAddr_r;
      awHeld_nxt = awHeld_r;
      wData_nxt = wData_r;
      wStrb_nxt = wStrb_r;
      wHeld_nxt = wHeld_r;
      bValid_nxt = bValid_r && !s_axi_bready;
      bResp_nxt = bResp_r;
      rValid_nxt = rValid_r && !s_axi_rready;
      rData_nxt = rData_r;
      rResp_nxt = rResp_r;
      cfg_nxt = cfg_r;
      go = 1'b0;
      merged = '0;
      if (s_axi_awvalid && s_axi_awready) begin
         awAddr_nxt = s_axi_awaddr;
         awHeld_nxt = 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         wData_nxt = s_axi_wdata;
         wStrb_nxt = s_axi_wstrb;
         wHeld_nxt = 1'b1;
      end
      if (doWrite) begin
         awHeld_nxt = 1'b0;
         wHeld_nxt = 1'b0;
         bValid_nxt = 1'b1;
         bResp_nxt = `TDFS_RESP_OKAY;
         unique case (awAddr_r)
            `TDFS_OFF_CTRL: merged = ctrlRd;
            `TDFS_OFF_ITER: merged = iterRd;
            `TDFS_OFF_CRC: merged = crcRd;
            `TDFS_OFF_POLY: merged = cfg_r.poly;
            `TDFS_OFF_STAT: merged = statRd;
            default: bResp_nxt = `TDFS_RESP_SLVERR;
         endcase
         for (int i = 0; i < 4; i++) begin
            if (wStrb_r[i]) begin
               merged[i*8 +: 8] = wData_r[i*8 +: 8];
            end
         end
         unique case (awAddr_r)
            `TDFS_OFF_CTRL: begin
               go = wStrb_r[0] && wData_r[`TDFS_CTRL_GO];
               cfg_nxt.little = merged[`TDFS_CTRL_LITTLE];
               cfg_nxt.intrSel = merged[`TDFS_CTRL_INTR];
               cfg_nxt.msbFirst = merged[`TDFS_CTRL_MSBF];
            end
            `TDFS_OFF_ITER: begin
               cfg_nxt.minIter = merged[4:0];
               cfg_nxt.maxIter = merged[12:8];
               cfg_nxt.snrThr = merged[22:16];
            end
            `TDFS_OFF_CRC: begin
               cfg_nxt.crcPolyLength = merged[5:0] > 6'h20 ? 6'h20 : merged[5:0];
               cfg_nxt.crcConsecutivePassCount = merged[12:8];
            end
            `TDFS_OFF_POLY: cfg_nxt.poly = merged;
            default: ;
         endcase
      end
      if (s_axi_arvalid && s_axi_arready) begin
         rValid_nxt = 1'b1;
         rResp_nxt = `TDFS_RESP_OKAY;
         unique case (s_axi_araddr)
            `TDFS_OFF_CTRL: rData_nxt = ctrlRd;
            `TDFS_OFF_ITER: rData_nxt = iterRd;
            `TDFS_OFF_CRC: rData_nxt = crcRd;
            `TDFS_OFF_POLY: rData_nxt = cfg_r.poly;
            `TDFS_OFF_STAT: rData_nxt = statRd;
            default: begin
               rData_nxt = '0;
               rResp_nxt = `TDFS_RESP_SLVERR;
            end
         endcase
      end
   end

   assign doWrite = awHeld_r && wHeld_r && !bValid_r;
   assign s_axi_awready = !awHeld_r;
   assign s_axi_wready = !wHeld_r;
   assign s_axi_arready = !rValid_r;

   // stop evaluation only after the first MAP, so the last iteration ends there
   assign maxEff = cfg_r.maxIter == 5'h00 ? `TDFS_MAX_ITER_ZERO : {1'b0, cfg_r.maxIter};
   assign minEff = cfg_r.minIter == 5'h00 ? `TDFS_MIN_ITER_ZERO : {1'b0, cfg_r.minIter};
   assign passReq = cfg_r.crcConsecutivePassCount == 5'h00 ? 5'h01 : cfg_r.crcConsecutivePassCount;
   assign snrEn = cfg_r.snrThr != 7'h00;
   assign crcEn = cfg_r.crcPolyLength != 6'h00;
   assign crcMet = crcCnt_r >= passReq;
   assign iterInc = iter_r + 6'h01;
   assign lenM1 = cfg_r.crcPolyLength - 6'h01;
   assign lenMask = cfg_r.crcPolyLength[5] ? 32'hFFFF_FFFF
                    : ((32'h0000_0001 << cfg_r.crcPolyLength[4:0]) - 32'h0000_0001);
   assign fb = crc_r[lenM1[4:0]] ^ decBit;
   assign crcStep = ((crc_r << 1) ^ (fb ? cfg_r.poly : 32'h0000_0000)) & lenMask;

   always_comb begin
      st_nxt = st_r;
      iter_nxt = iter_r;
      iterRun_nxt = iterRun_r;
      snrPrev_nxt = snrPrev_r;
      snrMet_nxt = snrMet_r;
      crcCnt_nxt = crcCnt_r;
      crc_nxt = crc_r;
      decPass_nxt = decPass_r;
      done_nxt = done_r;
      evt_nxt = 1'b0;
      mapStart_nxt = 1'b0;
      hardStart_nxt = 1'b0;
      earlyOk = (snrEn || crcEn) && (!snrEn || snrMet_r) && (!crcEn || crcMet)
                && iter_r >= minEff;
      unique case (st_r)
         ST_IDLE: begin
            if (go) begin
               st_nxt = ST_MAP1;
               mapStart_nxt = 1'b1;
               iter_nxt = '0;
               snrPrev_nxt = 1'b0;
               snrMet_nxt = 1'b0;
               crcCnt_nxt = '0;
               decPass_nxt = 1'b0;
               done_nxt = 1'b0;
            end
         end
         ST_MAP1: begin
            if (mapDone) begin
               iter_nxt = iterInc;
               snrPrev_nxt = snrAbove;
               snrMet_nxt = snrEn && snrAbove && snrPrev_r;
               hardStart_nxt = 1'b1;
               if (iterInc >= maxEff) begin
                  st_nxt = ST_FINAL;
               end else if (crcEn && iterInc >= minEff) begin
                  st_nxt = ST_HARD;
                  crc_nxt = '0;
               end else begin
                  st_nxt = ST_MAP2;
                  hardStart_nxt = 1'b0;
                  mapStart_nxt = 1'b1;
               end
            end
         end
         ST_HARD: begin
            if (decValid) begin
               crc_nxt = crcStep;
               if (decLast) begin
                  // a failing frame restarts the run of passes
                  crcCnt_nxt = crcStep == 32'h0000_0000 ? crcCnt_r + 5'h01 : 5'h00;
                  st_nxt = ST_MAP2;
                  mapStart_nxt = 1'b1;
               end
            end
         end
         ST_MAP2: begin
            if (earlyOk) begin
               st_nxt = ST_FINAL;
               hardStart_nxt = 1'b1;
            end else if (mapDone) begin
               snrPrev_nxt = snrAbove;
               st_nxt = ST_MAP1;
               mapStart_nxt = 1'b1;
            end
         end
         ST_FINAL: begin
            if (decValid && decLast) begin
               st_nxt = ST_DONE;
            end
         end
         ST_DONE: begin
            st_nxt = ST_IDLE;
            evt_nxt = 1'b1;
            done_nxt = 1'b1;
            iterRun_nxt = iter_r;
            decPass_nxt = crcEn && crcMet;
         end
      endcase
   end

   // a pending early stop is acted on before the second MAP is started
   assign mapStart = mapStart_r && !(st_r == ST_MAP2 && earlyOk);
   assign mapInterleaved = st_r == ST_MAP2;
   assign snrThreshold = cfg_r.snrThr;
   assign hardStart = hardStart_r;
   assign decoderReceiveReadyEvent = evt_r;

   tdfs_endian uEndian (
      .little(cfg_r.little),
      .intrSel(cfg_r.intrSel),
      .dwIn(tblData),
      .dwOut(dwSwap)
   );

   always_comb begin
      dw_nxt = dw_r;
      dwHeld_nxt = dwHeld_r;
      hw_nxt = hw_r;
      rdEn_nxt = 1'b0;
      rdAddr_nxt = rdAddr_r;
      ilv_nxt = ilv_r;
      ilvV_nxt = rdEn_r;
      if (rdEn_r) begin
         ilv_nxt = sampRdData;
      end
      if (tblValid && !dwHeld_r) begin
         dw_nxt = dwSwap;
         dwHeld_nxt = 1'b1;
         hw_nxt = '0;
      end else if (dwHeld_r) begin
         rdEn_nxt = 1'b1;
         rdAddr_nxt = dw_r[hw_r*16 +: `TDFS_IDX_BITS];
         hw_nxt = hw_r + 2'h1;
         dwHeld_nxt = hw_r != 2'h3;
      end
   end

   assign tblReady = !dwHeld_r;
   assign sampRdEn = rdEn_r;
   assign sampRdAddr = rdAddr_r;
   assign ilvSample = ilv_r;
   assign ilvValid = ilvV_r;

   tdfs_pack uPack (
      .ref_clk(ref_clk),
      .arst_n(arst_n),
      .enable(st_r == ST_FINAL),
      .msbFirst(cfg_r.msbFirst),
      .bitIn(decBit),
      .bitValid(decValid),
      .bitLast(decLast),
      .word(decWord),
      .wordValid(decWordValid)
   );

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         cfg_r <= {`TDFS_POLY_RST, 6'(`TDFS_CRC_RST), 5'(`TDFS_CRC_RST >> 8),
                   7'(`TDFS_ITER_RST >> 16), 5'(`TDFS_ITER_RST >> 8), 5'(`TDFS_ITER_RST),
                   3'(`TDFS_CTRL_RST >> 1)};
         awAddr_r <= '0;
         awHeld_r <= 1'b0;
         wData_r <= '0;
         wStrb_r <= '0;
         wHeld_r <= 1'b0;
         bValid_r <= 1'b0;
         bResp_r <= '0;
         rValid_r <= 1'b0;
         rData_r <= '0;
         rResp_r <= '0;
         st_r <= ST_IDLE;
         iter_r <= '0;
         iterRun_r <= '0;
         snrPrev_r <= 1'b0;
         snrMet_r <= 1'b0;
         crcCnt_r <= '0;
         crc_r <= '0;
         decPass_r <= 1'b0;
         done_r <= 1'b0;
         evt_r <= 1'b0;
         mapStart_r <= 1'b0;
         hardStart_r <= 1'b0;
         dw_r <= '0;
         dwHeld_r <= 1'b0;
         hw_r <= '0;
         rdEn_r <= 1'b0;
         rdAddr_r <= '0;
         ilv_r <= '0;
         ilvV_r <= 1'b0;
      end else begin
         cfg_r <= cfg_nxt;
         awAddr_r <= awAddr_nxt;
         awHeld_r <= awHeld_nxt;
         wData_r <= wData_nxt;
         wStrb_r <= wStrb_nxt;
         wHeld_r <= wHeld_nxt;
         bValid_r <= bValid_nxt;
         bResp_r <= bResp_nxt;
         rValid_r <= rValid_nxt;
         rData_r <= rData_nxt;
         rResp_r <= rResp_nxt;
         st_r <= st_nxt;
         iter_r <= iter_nxt;
         iterRun_r <= iterRun_nxt;
         snrPrev_r <= snrPrev_nxt;
         snrMet_r <= snrMet_nxt;
         crcCnt_r <= crcCnt_nxt;
         crc_r <= crc_nxt;
         decPass_r <= decPass_nxt;
         done_r <= done_nxt;
         evt_r <= evt_nxt;
         mapStart_r <= mapStart_nxt;
         hardStart_r <= hardStart_nxt;
         dw_r <= dw_nxt;
         dwHeld_r <= dwHeld_nxt;
         hw_r <= hw_nxt;
         rdEn_r <= rdEn_nxt;
         rdAddr_r <= rdAddr_nxt;
         ilv_r <= ilv_nxt;
         ilvV_r <= ilvV_nxt;
      end
   end

   assign s_axi_bvalid = bValid_r;
   assign s_axi_bresp = bResp_r;
   assign s_axi_rvalid = rValid_r;
   assign s_axi_rdata = rData_r;
   assign s_axi_rresp = rResp_r;
endmodule

// file: tdfs_far_model.sv
// far side of the format and stop block: map engine, decision source, sample store
// assumes the block's pulses on ref_clk; map answers come four cycles after a start
`timescale 1ns/100ps
module tdfs_far_model (
   // clock and reset
   input wire logic ref_clk,
   input wire logic arst_n,
   // bench controls
   input wire logic runClr,
   input wire logic [1:0] snrMode,
   input wire logic [31:0] pat,
   input wire logic [3:0] failHard,
   // block side
   input wire logic mapStart,
   input wire logic hardStart,
   input wire logic sampRdEn,
   input wire logic [14:0] sampRdAddr,
   output logic mapDone,
   output logic snrAbove,
   output logic decBit,
   output logic decValid,
   output logic decLast,
   output logic [5:0] sampRdData
);
   logic [2:0] mapCnt;
   logic [5:0] bitCnt;
   logic [4:0] idx;
   logic [3:0] hardCnt;
   logic alt;
   assign idx = 5'(6'd32 - bitCnt);
   // store answers within the read cycle; idle shows the inverse, never stale data
   assign sampRdData = sampRdEn ? sampRdAddr[5:0] : ~sampRdAddr[5:0];
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         mapCnt <= '0;
         bitCnt <= '0;
         hardCnt <= '0;
         alt <= 1'b0;
         mapDone <= 1'b0;
         snrAbove <= 1'b0;
         decBit <= 1'b0;
         decValid <= 1'b0;
         decLast <= 1'b0;
      end else begin
         mapDone <= mapCnt == 3'd1;
         // between answers the flag toggles every cycle, so it shows junk rather than a held verdict
         snrAbove <= (mapCnt == 3'd1) ? (snrMode == 2'd1 || (snrMode == 2'd2 && alt)) : ~snrAbove;
         alt <= runClr ? 1'b0 : alt ^ (mapCnt == 3'd1);
         mapCnt <= mapStart ? 3'd3 : (mapCnt != 3'd0 ? mapCnt - 3'd1 : 3'd0);
         hardCnt <= runClr ? 4'd0 : hardCnt + 4'(hardStart);
         bitCnt <= hardStart ? 6'd32 : (bitCnt != 6'd0 ? bitCnt - 6'd1 : 6'd0);
         decValid <= bitCnt != 6'd0;
         decLast <= bitCnt == 6'd1;
         // last bit flipped on the chosen pass so its check fails
         decBit <= (bitCnt != 6'd0) ? (pat[idx] ^ (idx == 5'd31 && hardCnt == failHard)) : ~decBit;
      end
   end
endmodule

// file: tdfs_chk.sv
// port assertions of the format and stop block
// assumes one clock domain; bound to tdfs_top below
`timescale 1ns/100ps
module tdfs_chk (
   // clock and reset
   input wire logic ref_clk,
   input wire logic arst_n,
   // register bus
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_bvalid,
   // decoding
   input wire logic mapStart,
   input wire logic mapDone,
   input wire logic hardStart,
   input wire logic decLast,
   input wire logic [6:0] snrThreshold,
   input wire logic sampRdEn,
   input wire logic ilvValid,
   input wire logic decoderReceiveReadyEvent
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!arst_n);
   sequence s_next_step;
      ##[1:2] (mapStart || hardStart);
   endsequence
   sequence s_ilv_out;
      ##1 ilvValid;
   endsequence
   a_map_pulse: assert property (mapStart |=> !mapStart)
      else $error("map start wider than one cycle");
   a_map_next: assert property (mapDone |-> s_next_step)
      else $error("no next step after map done");
   a_event_pulse: assert property (decoderReceiveReadyEvent |=> !decoderReceiveReadyEvent)
      else $error("ready event wider than one cycle");
   a_event_cause: assert property (decoderReceiveReadyEvent |-> $past(decLast, 2) || $past(decLast, 3))
      else $error("ready event without final decisions");
   a_ilv_follow: assert property (sampRdEn |-> s_ilv_out)
      else $error("sample read without interleaved output");
   a_ilv_cause: assert property (ilvValid |-> $past(sampRdEn))
      else $error("interleaved output without sample read");
   a_snr_write: assert property ($changed(snrThreshold) |-> ##[0:1] s_axi_bvalid)
      else $error("threshold changed without a write");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read not answered next cycle");
endmodule
bind tdfs_top tdfs_chk i_tdfs_chk (.*);

// file: tb.sv
// self-checking bench of the format and stop block
// assumes package, register header, far model and checker compiled first
`timescale 1ns/100ps
`include "tdfs_regs.svh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin error_cnt++; \
   $display("ERROR %s exp %0h got %0h", nm, e, g); end end
module tb;
   logic ref_clk = 1'b0;
   logic arst_n = 1'b0;
   logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
   logic s_axi_rready = 0, tblValid = 0, runClr = 0;
   logic [31:0] s_axi_wdata = '0, pat = '0, s_axi_rdata, decWord, rd;
   logic [3:0] s_axi_wstrb = 4'hF, failHard = '0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, rsp, snrMode = '0;
   logic mapStart, mapInterleaved, mapDone, snrAbove, hardStart, decBit, decValid, decLast;
   logic tblReady, sampRdEn, ilvValid, decWordValid, decoderReceiveReadyEvent;
   logic [6:0] snrThreshold;
   logic [63:0] tblData = '0;
   logic [14:0] sampRdAddr;
   logic [5:0] sampRdData, ilvSample;
   int error_cnt = 0, n_tests = 0, cyc = 0, maps = 0, evs = 0, imaps = 0;
   logic [31:0] words[$];
   logic [5:0] ilvQ[$];
   logic [7:0] offs[5] = '{`TDFS_OFF_CTRL, `TDFS_OFF_ITER, `TDFS_OFF_CRC, `TDFS_OFF_POLY, 8'h10};
   logic [31:0] rsts[5] = '{`TDFS_CTRL_RST, `TDFS_ITER_RST, `TDFS_CRC_RST, `TDFS_POLY_RST, 0};
   tdfs_top i_tdfs_top (.*);
   tdfs_far_model i_tdfs_far_model (.*);
   initial begin
      forever #5 ref_clk = ~ref_clk;
   end
   task automatic stop_test;
      if (error_cnt == 0 && n_tests > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (mapStart) maps <= maps + 1;
      if (mapStart && mapInterleaved) imaps <= imaps + 1;
      if (decoderReceiveReadyEvent) evs <= evs + 1;
      if (hardStart) words.delete();
      if (decWordValid) words.push_back(decWord);
      if (ilvValid) ilvQ.push_back(ilvSample);
      if (cyc == 20000) begin
         error_cnt++;
         $display("ERROR timeout exp 0 got 1");
         stop_test();
      end
   end
   task automatic axw(input logic [7:0] a, input logic [31:0] d);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      forever begin
         @(posedge ref_clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      rsp = s_axi_bresp;
      s_axi_bready <= 1'b0;
      @(posedge ref_clk);
   endtask
   task automatic axr(input logic [7:0] a);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      forever begin
         @(posedge ref_clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
      end
      rd = s_axi_rdata;
      rsp = s_axi_rresp;
      s_axi_rready <= 1'b0;
      @(posedge ref_clk);
   endtask
   // top bit of every entry set: it must not reach the address
   task automatic ilv(input logic [31:0] ctrl, input logic [15:0] ord);
      axw(`TDFS_OFF_CTRL, ctrl);
      ilvQ.delete();
      tblData <= 64'h8004_8003_8002_8001;
      tblValid <= 1'b1;
      do @(posedge ref_clk); while (!tblReady);
      tblValid <= 1'b0;
      tblData <= 64'h7FFB_7FFC_7FFD_7FFE;
      repeat (8) @(posedge ref_clk);
      `CHK("ilv count", 4, ilvQ.size())
      for (int k = 0; k < 4; k++) `CHK("ilv sample", 6'(ord[15-4*k -: 4]), ilvQ[k])
   endtask
   task automatic run(input logic [31:0] ctrl, iter, crc, input logic [1:0] m,
                      input logic [3:0] f, input logic [31:0] p, st, input int nm);
      logic [31:0] w;
      w = p;
      if (ctrl[`TDFS_CTRL_MSBF]) w = {<<{p}};
      snrMode <= m;
      failHard <= f;
      pat <= p;
      runClr <= 1'b1;
      @(posedge ref_clk);
      runClr <= 1'b0;
      axw(`TDFS_OFF_ITER, iter);
      axw(`TDFS_OFF_CRC, crc);
      axw(`TDFS_OFF_POLY, 32'h0000_0007);
      maps = 0;
      imaps = 0;
      evs = 0;
      axw(`TDFS_OFF_CTRL, ctrl);
      while (evs == 0) @(posedge ref_clk);
      repeat (4) @(posedge ref_clk);
      axr(`TDFS_OFF_STAT);
      `CHK("status", st, rd & 32'h0000_053F)
      `CHK("map starts", nm, maps)
      `CHK("interleaved maps", nm / 2, imaps)
      `CHK("events", 1, evs)
      `CHK("word count", 2, words.size())
      `CHK("word", w, words[0])
      `CHK("pad word", 32'h0, words[1])
   endtask
   initial begin
      repeat (10) @(posedge ref_clk);
      arst_n <= 1'b1;
      @(posedge ref_clk);
      axw(`TDFS_OFF_STAT, 32'hFFFF_FFFF);
      for (int k = 0; k < 5; k++) begin
         axr(offs[k]);
         `CHK("reset value", rsts[k], rd)
      end
      axw(`TDFS_OFF_ITER, 32'h0064_1F05);
      axr(`TDFS_OFF_ITER);
      `CHK("iter", 32'h0064_1F05, rd)
      `CHK("snr out", 7'h64, snrThreshold)
      axw(`TDFS_OFF_POLY, 32'hEDB8_8320);
      axr(`TDFS_OFF_POLY);
      `CHK("poly", 32'hEDB8_8320, rd)
      axw(8'h40, 32'h0000_FFFF);
      `CHK("bad write", `TDFS_RESP_SLVERR, rsp)
      axr(8'h40);
      `CHK("bad read", `TDFS_RESP_SLVERR, rsp)
      `CHK("bad data", 32'h0, rd)
      ilv(32'h0000_0002, 16'h1234);
      ilv(32'h0000_0000, 16'h3412);
      ilv(32'h0000_0004, 16'h4321);
      run(32'h3, 32'h0000_0300, 0, 2'd1, 0, 32'h0000_A5C3, 32'h0000_0403, 5);
      run(32'hB, 32'h0000_0000, 0, 2'd1, 0, 32'h0000_A5C3, 32'h0000_0420, 63);
      run(32'h3, 32'h0064_0A00, 0, 2'd1, 0, 32'h0000_A5C3, 32'h0000_0402, 3);
      run(32'h3, 32'h0064_0A04, 0, 2'd1, 0, 32'h0000_A5C3, 32'h0000_0404, 7);
      run(32'h3, 32'h0064_0500, 0, 2'd2, 0, 32'h0000_A5C3, 32'h0000_0405, 9);
      run(32'h3, 32'h0000_0800, 32'h0000_0203, 2'd0, 0, 0, 32'h0000_0502, 3);
      run(32'h3, 32'h0000_0800, 32'h0000_0203, 2'd0, 2, 0, 32'h0000_0504, 7);
      stop_test();
   end
endmodule
